//--- logic/ccvf_video.sv
// Function
// - Reverse bit shows dark on lit background
// - Intensity bit drives lit pixels high intensity
// - Underline bit draws one-pixel line at bottom
// - Underline row chosen by font marker bit
// - Strikethrough drawn on font-marked middle line
// - Software-reserved attribute bit is ignored
// - 11-bit pointer addresses word-aligned font cell
// - Sixteen-word cell, line picked by scan row
// - LSB leftmost, first word top, set lit
// - Fetch screen word at controller word address
// - Attributes split off and held for later
// - Line word shifted out one pixel per clock
// - Pixels merged with attributes and sync out
// - Select at port 68H, contents at 6AH
// - Written cursor position moves cursor reference
// - Screen buffer is 4K bytes at F0000
// - Buffer words in raster order from top-left
`timescale 1ns/1ps

module ccvf_video
  import ccvf_pkg::*;
#(
  parameter int CELL_W     = `CCVF_CELL_W,
  parameter int FIFO_DEPTH = `CCVF_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       nrst_in,
  // Host I/O port
  input  wire logic [7:0]                 io_addr_in,
  input  wire logic                       io_wr_in,
  input  wire logic                       io_rd_in,
  input  wire logic [7:0]                 io_wdata_in,
  output logic [7:0]                      io_rdata_out,
  // CRT controller pins
  input  wire logic                       crtc_cclk_in,
  input  wire logic                       crtc_de_in,
  input  wire logic                       crtc_hsync_in,
  input  wire logic                       crtc_vsync_in,
  input  wire logic [3:0]                 crtc_row_in,
  input  wire logic [`CCVF_SCREEN_AW-1:0] crtc_addr_in,
  // Memory read port
  output logic                            mem_req_out,
  output logic [19:0]                     mem_addr_out,
  input  wire logic                       mem_ack_in,
  input  wire logic [15:0]                mem_data_in,
  // CRT drive
  output logic                            video_on_out,
  output logic                            video_hi_out,
  output logic                            hsync_out,
  output logic                            vsync_out,
  // Status
  output logic                            overrun_out
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    ccvf_pins_t                        sync1;   // First synchroniser stage
    ccvf_pins_t                        sync2;   // Second synchroniser stage
    logic                              cclk_d;  // Character clock, last cycle
    ccvf_fetch_t                       fetch;   // Fetch sequencer
    logic [`CCVF_SCREEN_AW-1:0]        addr;    // Character being fetched
    logic [3:0]                        row;     // Its scan row
    ccvf_attr_t                        attr;    // Held attributes
    logic [`CCVF_PTR_W-1:0]            ptr;     // Font cell pointer
    logic                              cursor;  // Character under cursor
    logic [15:0]                       line;    // Fetched font line word
    logic                              req;     // Memory request
    logic [19:0]                       maddr;   // Memory byte address
    logic                              overrun; // Character dropped, sticky
    logic [`CCVF_SEL_W-1:0]            sel;     // Selected register
    logic [`CCVF_NUM_REGS-1:0][7:0]    regs;    // Controller registers
    logic [7:0]                        rdata;   // Read data
    logic [15:0]                       shift;   // Video shift register
    ccvf_attr_t                        pattr;   // Attributes in the shifter
    logic                              pcur;    // Cursor in the shifter
    logic                              pfill;   // Underline or strike line
    logic [4:0]                        pcnt;    // Pixels left
    logic                              von;     // Video out
    logic                              vhi;     // High intensity out
    logic                              hs;      // Horizontal sync out
    logic                              vs;      // Vertical sync out
  } ccvf_st_t;

  ccvf_st_t    st;        // Registered state
  ccvf_st_t    next_st;   // Next state
  ccvf_pins_t  pins;      // Raw pins gathered
  ccvf_io_t    io;        // Host cycle gathered
  ccvf_entry_t push_d;    // Entry into the FIFO
  ccvf_entry_t pop_d;     // Entry out of the FIFO
  logic        push_rdy;  // FIFO has room
  logic        pop_vld;   // FIFO has data
  logic        pop;       // Output stage takes an entry

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Port match, used for both reads and writes
  function automatic logic port_hit(input logic [7:0] a, input logic [7:0] p);
    port_hit = (a == p);
  endfunction : port_hit

  // Screen word to processed attributes; reserved bit never looked at
  function automatic ccvf_attr_t split_attr(input logic [15:0] w);
    split_attr.rev    = w[`CCVF_ATTR_REV];
    split_attr.hi     = w[`CCVF_ATTR_INT];
    split_attr.ul     = w[`CCVF_ATTR_UL];
    split_attr.strike = w[`CCVF_ATTR_STRIKE];
  endfunction : split_attr

  // Register index is one of the eighteen
  function automatic logic reg_valid(input logic [`CCVF_SEL_W-1:0] s);
    reg_valid = (s < `CCVF_SEL_W'(`CCVF_NUM_REGS));
  endfunction : reg_valid

  assign pins = '{cclk: crtc_cclk_in, de: crtc_de_in, hs: crtc_hsync_in,
                  vs: crtc_vsync_in, row: crtc_row_in, addr: crtc_addr_in};
  assign io   = '{wr: io_wr_in, rd: io_rd_in, addr: io_addr_in, data: io_wdata_in};

  //////////////////////////////////////////////////////////////////////////////
  // FIFO between fetch and the output stage

  // Output stage takes a new entry when the last pixel has gone
  assign pop = pop_vld && (st.pcnt == 5'h00);

  assign push_d = '{line: st.line, attr: st.attr, cursor: st.cursor};

  ccvf_fifo #(
    .WIDTH ($bits(ccvf_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .wr_valid_in  (st.fetch == CCVF_PUSH),
    .wr_data_in   (push_d),
    .wr_ready_out (push_rdy),
    .rd_valid_out (pop_vld),
    .rd_data_out  (pop_d),
    .rd_ready_in  (pop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic new_char;
    logic [`CCVF_SCREEN_AW-1:0] cur_pos;
    logic pix;
    new_char = 1'b0;
    cur_pos  = '0;
    pix      = 1'b0;
    next_st  = st;

    // Pins pass two flops before anything reads them
    next_st.sync1  = pins;
    next_st.sync2  = st.sync1;
    next_st.cclk_d = st.sync2.cclk;
    new_char = st.sync2.cclk && !st.cclk_d && st.sync2.de;

    // Host writes: select at one port, contents at the other
    if (io.wr && port_hit(io.addr, `CCVF_PORT_SELECT)) begin
      next_st.sel = io.data[`CCVF_SEL_W-1:0];
    end
    if (io.wr && port_hit(io.addr, `CCVF_PORT_CONTENTS) && reg_valid(st.sel)) begin
      next_st.regs[st.sel] = io.data;
    end
    // Host reads; select port is write-only and reads zero
    if (io.rd) begin
      if (port_hit(io.addr, `CCVF_PORT_CONTENTS) && reg_valid(st.sel)) begin
        next_st.rdata = st.regs[st.sel];
      end else begin
        next_st.rdata = 8'h00;
      end
    end
    // Address registers show the character being fetched
    next_st.regs[`CCVF_REG_ADDR_HI] = 8'(st.addr >> 8);
    next_st.regs[`CCVF_REG_ADDR_LO] = st.addr[7:0];

    // Cursor reference comes from the host-written position
    cur_pos = {st.regs[`CCVF_REG_CURSOR_HI][`CCVF_SCREEN_AW-9:0],
               st.regs[`CCVF_REG_CURSOR_LO]};

    // Fetch sequencer
    unique case (st.fetch)
      CCVF_IDLE: begin
        if (new_char) begin
          // Word address scaled to bytes in the buffer, raster order
          next_st.addr  = st.sync2.addr;
          next_st.row   = st.sync2.row;
          next_st.req   = 1'b1;
          next_st.maddr = `CCVF_SCREEN_BASE | 20'({st.sync2.addr, 1'b0});
          next_st.fetch = CCVF_SCREEN;
        end
      end
      CCVF_SCREEN: begin
        if (mem_ack_in) begin
          // Attributes held aside, pointer selects the cell
          next_st.attr   = split_attr(mem_data_in);
          next_st.ptr    = mem_data_in[`CCVF_PTR_W-1:0];
          next_st.cursor = (st.addr == cur_pos) &&
                           !st.regs[`CCVF_REG_CURSOR_CFG][`CCVF_CURSOR_OFF_BIT];
          // Cell base plus one word per scan row, lowest 32k only
          next_st.maddr  = 20'({mem_data_in[`CCVF_PTR_W-1:0], 4'h0}) +
                           20'({st.row, 1'b0});
          next_st.fetch  = CCVF_FONT;
        end
      end
      CCVF_FONT: begin
        if (mem_ack_in) begin
          next_st.line  = mem_data_in;
          next_st.req   = 1'b0;
          next_st.fetch = CCVF_PUSH;
        end
      end
      CCVF_PUSH: begin
        // Waits here while the FIFO is full
        if (push_rdy) begin
          next_st.fetch = CCVF_IDLE;
        end
      end
    endcase

    // A character that arrives while busy is lost; flag it, set wins
    if (new_char && (st.fetch != CCVF_IDLE)) begin
      next_st.overrun = 1'b1;
    end else if (io.rd && port_hit(io.addr, `CCVF_PORT_SELECT)) begin
      next_st.overrun = 1'b0;
    end

    // Video shift register: load on empty, else shift one pixel a clock
    if (pop) begin
      next_st.shift = pop_d.line;
      next_st.pattr = pop_d.attr;
      next_st.pcur  = pop_d.cursor;
      next_st.pfill = (pop_d.attr.ul && pop_d.line[`CCVF_MARK_UL]) ||
                      (pop_d.attr.strike && pop_d.line[`CCVF_MARK_STRIKE]);
      next_st.pcnt  = 5'(CELL_W);
    end else if (st.pcnt != 5'h00) begin
      next_st.shift = st.shift >> 1;
      next_st.pcnt  = st.pcnt - 5'h01;
    end

    // Output: LSB is the leftmost pixel, set bit lights it
    if (st.pcnt != 5'h00) begin
      pix = st.shift[0] | st.pfill;
      pix = pix ^ st.pattr.rev ^ st.pcur;
      next_st.von = pix;
      next_st.vhi = pix && st.pattr.hi;
    end else begin
      // Blank between characters and while starved
      next_st.von = 1'b0;
      next_st.vhi = 1'b0;
    end
    next_st.hs = st.sync2.hs;
    next_st.vs = st.sync2.vs;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st       <= '0;
      st.fetch <= CCVF_IDLE;
      st.sel   <= `CCVF_SEL_RESET;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign io_rdata_out = st.rdata;
  assign mem_req_out  = st.req;
  assign mem_addr_out = st.maddr;
  assign video_on_out = st.von;
  assign video_hi_out = st.vhi;
  assign hsync_out    = st.hs;
  assign vsync_out    = st.vs;
  assign overrun_out  = st.overrun;

endmodule : ccvf_video

//--- logic/ccvf_regs.svh
`ifndef CCVF_REGS_SVH
`define CCVF_REGS_SVH

// Host I/O ports of the controller register file
`define CCVF_PORT_SELECT     8'h68
`define CCVF_PORT_CONTENTS   8'h6a

// Controller register file
`define CCVF_NUM_REGS        18
`define CCVF_SEL_W           5
`define CCVF_REG_RESET       8'h00
`define CCVF_SEL_RESET       5'h00
`define CCVF_REG_CURSOR_CFG  5'h0a
`define CCVF_REG_CURSOR_HI   5'h0e
`define CCVF_REG_CURSOR_LO   5'h0f
`define CCVF_REG_ADDR_HI     5'h10
`define CCVF_REG_ADDR_LO     5'h11
`define CCVF_CURSOR_OFF_BIT  5

// Screen buffer: 4K bytes at F0000, one word per character
`define CCVF_SCREEN_BASE     20'hf0000
`define CCVF_SCREEN_AW       11

// Screen word layout
`define CCVF_PTR_W           11
`define CCVF_ATTR_REV        11
`define CCVF_ATTR_INT        12
`define CCVF_ATTR_UL         13
`define CCVF_ATTR_STRIKE     14
`define CCVF_ATTR_SWRES      15

// Font cell: 16 words, pointer addresses lowest 32k on word boundary
`define CCVF_FONT_LINES      16
`define CCVF_CELL_W          10
`define CCVF_MARK_STRIKE     13
`define CCVF_MARK_UL         14

// Data FIFO
`define CCVF_FIFO_DEPTH      16

`endif

//--- logic/ccvf_pkg.sv
`include "ccvf_regs.svh"

package ccvf_pkg;

  // Processed attributes of one character
  typedef struct packed {
    logic rev;
    logic hi;
    logic ul;
    logic strike;
  } ccvf_attr_t;

  // One FIFO entry: font line word plus what the output stage needs
  typedef struct packed {
    logic [15:0] line;
    ccvf_attr_t  attr;
    logic        cursor;
  } ccvf_entry_t;

  // Pins coming from the external CRT controller
  typedef struct packed {
    logic        cclk;
    logic        de;
    logic        hs;
    logic        vs;
    logic [3:0]  row;
    logic [`CCVF_SCREEN_AW-1:0] addr;
  } ccvf_pins_t;

  // Host I/O cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } ccvf_io_t;

  // Fetch sequencer states
  typedef enum logic [1:0] {
    CCVF_IDLE,
    CCVF_SCREEN,
    CCVF_FONT,
    CCVF_PUSH
  } ccvf_fetch_t;

endpackage : ccvf_pkg

//--- logic/ccvf_fifo.sv
`timescale 1ns/1ps

module ccvf_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // Fill side
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  // Drain side
  output logic                  rd_valid_out,
  output logic [WIDTH-1:0]      rd_data_out,
  input  wire logic             rd_ready_in
);

  localparam int AW = $clog2(DEPTH);

  // Whole FIFO state, storage included
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } ccvf_fifo_st_t;

  ccvf_fifo_st_t st;       // Registered state
  ccvf_fifo_st_t next_st;  // Next state

  // Pointer step with wrap, used by both ends
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  // Honest flags straight from the count
  assign wr_ready_out = (st.cnt != (AW+1)'(DEPTH));
  assign rd_valid_out = (st.cnt != '0);
  assign rd_data_out  = st.mem[st.rp];

  // Push and pop may happen in the same cycle
  always_comb begin
    next_st = st;
    if (wr_valid_in && wr_ready_out) begin
      next_st.mem[st.wp] = wr_data_in;
      next_st.wp         = bump(st.wp);
    end
    if (rd_valid_out && rd_ready_in) begin
      next_st.rp = bump(st.rp);
    end
    case ({wr_valid_in && wr_ready_out, rd_valid_out && rd_ready_in})
      2'b10:   next_st.cnt = st.cnt + (AW+1)'(1);
      2'b01:   next_st.cnt = st.cnt - (AW+1)'(1);
      default: next_st.cnt = st.cnt;
    endcase
  end

  // State register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : ccvf_fifo

//--- tb/ccvf_video_monitor.sv
`timescale 1ns/1ps

module ccvf_video_monitor (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        nrst_in,
  // Host port
  input wire logic [7:0]  io_addr_in,
  input wire logic        io_rd_in,
  input wire logic [7:0]  io_rdata_out,
  // Controller pins
  input wire logic        crtc_hsync_in,
  input wire logic        crtc_vsync_in,
  input wire logic [3:0]  crtc_row_in,
  // Memory port
  input wire logic        mem_req_out,
  input wire logic [19:0] mem_addr_out,
  input wire logic        mem_ack_in,
  input wire logic [15:0] mem_data_in,
  // CRT drive
  input wire logic        video_on_out,
  input wire logic        video_hi_out,
  input wire logic        hsync_out,
  input wire logic        vsync_out
);
  default clocking mon_cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic [10:0] ptr_w;  // Font pointer field of the word on the bus
  assign ptr_w = mem_data_in[10:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Memory fetch
  a_req_addr_stable: assert property (
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)) else $error("addr moved");
  a_screen_base: assert property (
    $rose(mem_req_out) |-> mem_addr_out[19:12] == 8'hf0 && !mem_addr_out[0])
    else $error("screen fetch outside buffer");
  // The row pin is held steady by the bench across a fetch, so the sum is exact
  a_font_addr: assert property (
    mem_req_out && mem_ack_in && mem_addr_out[19:12] == 8'hf0 |=> mem_req_out &&
    mem_addr_out == {5'h00, $past(ptr_w), 4'h0} + {15'h0000, crtc_row_in, 1'b0})
    else $error("font address wrong");
  a_req_drops: assert property (
    mem_req_out && mem_ack_in && mem_addr_out[19:15] == 5'h00 |=> !mem_req_out)
    else $error("request after font word");

  ////////////////////////////////////////////////////////////////////////////////
  // Host reads
  a_rdata_holds: assert property (
    !io_rd_in |=> $stable(io_rdata_out)) else $error("read data moved");
  a_rd_other_zero: assert property (
    io_rd_in && io_addr_in != 8'h6a |=> io_rdata_out == 8'h00) else $error("bad read data");

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage
  a_hi_needs_on: assert property (
    video_hi_out |-> video_on_out) else $error("intensity on dark pixel");
  a_hsync_delay: assert property (
    hsync_out == $past(crtc_hsync_in, 3)) else $error("hsync latency");
  a_vsync_delay: assert property (
    vsync_out == $past(crtc_vsync_in, 3)) else $error("vsync latency");
endmodule : ccvf_video_monitor

//--- tb/ccvf_mem_model.sv
`timescale 1ns/1ps

module ccvf_mem_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Pace control
  input  wire logic        slow_in,
  // Read port
  input  wire logic        mem_req_in,
  input  wire logic [19:0] mem_addr_in,
  output logic             mem_ack_out,
  output logic [15:0]      mem_data_out
);
  logic [15:0] mem [int];  // Word store, key is byte address over two
  int          wait_cnt;   // Pause before the next answer

  // Answer after a pause, random or eight cycles when slow; outside the ack cycle the data flips every cycle, not stale
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_ack_out  <= 1'b0;
      mem_data_out <= 16'h0000;
      wait_cnt     <= 0;
    end else if (mem_req_in && !mem_ack_out && wait_cnt == 0) begin
      mem_ack_out  <= 1'b1;
      mem_data_out <= mem.exists(int'(mem_addr_in >> 1)) ? mem[int'(mem_addr_in >> 1)] : 16'h5a5a;
      wait_cnt     <= slow_in ? 8 : int'($urandom % 3);
    end else begin
      mem_ack_out  <= 1'b0;
      mem_data_out <= ~mem_data_out;
      if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule : ccvf_mem_model

//--- tb/tb_char_cell_video_fetch.sv
`timescale 1ns/1ps
`include "ccvf_regs.svh"

module tb_char_cell_video_fetch;
  logic        clk_in, nrst_in, io_wr_in, io_rd_in;  // Clock, reset, strobes
  logic [7:0]  io_addr_in, io_wdata_in, io_rdata_out; // Host port
  logic        cclk, de, hs, vs, slow;                // Controller pins, memory pace
  logic [3:0]  row;                                   // Scan row pin
  logic [10:0] caddr;                                 // Character address pin
  logic        mem_req, mem_ack, v_on, v_hi, hs_o, vs_o, ovr;
  logic [19:0] mem_addr;
  logic [15:0] mem_data;
  logic [7:0]  rd;
  int          bad_count, samples_checked;
  int          regs [18];                             // Register model

  ccvf_video dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .io_addr_in(io_addr_in),
    .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
    .io_rdata_out(io_rdata_out), .crtc_cclk_in(cclk), .crtc_de_in(de), .crtc_hsync_in(hs),
    .crtc_vsync_in(vs), .crtc_row_in(row), .crtc_addr_in(caddr), .mem_req_out(mem_req),
    .mem_addr_out(mem_addr), .mem_ack_in(mem_ack), .mem_data_in(mem_data),
    .video_on_out(v_on), .video_hi_out(v_hi), .hsync_out(hs_o), .vsync_out(vs_o),
    .overrun_out(ovr));
  ccvf_mem_model mem_u (.clk_in(clk_in), .nrst_in(nrst_in), .slow_in(slow),
    .mem_req_in(mem_req), .mem_addr_in(mem_addr), .mem_ack_out(mem_ack), .mem_data_out(mem_data));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // One write per call; the strobe drops a full cycle before the next call
  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    io_wr_in = 1'b1;
    io_addr_in = a;
    io_wdata_in = d;
    @(negedge clk_in);
    io_wr_in = 1'b0;
  endtask : io_write

  task automatic io_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    io_rd_in = 1'b1;
    io_addr_in = a;
    @(negedge clk_in);
    io_rd_in = 1'b0;
    @(negedge clk_in);
    d = io_rdata_out;
  endtask : io_read

  // Store screen and font words, raise one character edge, capture the pixel train
  task automatic run_char(input logic [10:0] a, input logic [3:0] r,
                          input logic [15:0] sw, input logic [15:0] fw, input logic cur);
    logic [47:0] won, whi, eon, ehi;
    logic        fill;
    fill = (sw[13] & fw[14]) | (sw[14] & fw[13]);
    eon = {38'h0, (fw[9:0] | {10{fill}}) ^ {10{sw[11] ^ cur}}};
    ehi = eon & {48{sw[12]}};
    mem_u.mem[int'((`CCVF_SCREEN_BASE + 2 * a) >> 1)] = sw;
    mem_u.mem[int'((sw[10:0] * 16 + r * 2) >> 1)] = fw;
    @(negedge clk_in);
    caddr = a;
    row = r;
    de = 1'b1;
    repeat (2) @(negedge clk_in);
    cclk = 1'b1;
    for (int i = 0; i < 48; i++) begin
      @(negedge clk_in);
      won[i] = v_on;
      whi[i] = v_hi;
    end
    cclk = 1'b0;
    de = 1'b0;
    // Memory pace varies, so the train is placed by search, order within it is exact
    for (int o = 0; o < 39; o++) begin
      if (won === (eon << o)) begin
        eon = eon << o;
        ehi = ehi << o;
        break;
      end
    end
    check({won, whi}, {eon, ehi});
  endtask : run_char

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {io_wr_in, io_rd_in, cclk, de, hs, vs, slow} = '0;
    {io_addr_in, io_wdata_in, row, caddr} = '0;
    nrst_in = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(32'h728e6e0d));
    repeat (8) @(negedge clk_in);
    nrst_in = 1'b1;
    // Program every register, cursor disabled
    for (int i = 0; i < 18; i++) begin
      regs[i] = (i == 10) ? 8'h20 : $urandom % 256;
      io_write(8'h68, i[7:0]);
      io_write(8'h6a, regs[i][7:0]);
    end
    for (int i = 0; i < 16; i++) begin
      io_write(8'h68, i[7:0]);
      io_read(8'h6a, rd);
      check(rd, regs[i][7:0]);
    end
    io_write(8'h68, 8'h14);
    io_write(8'h6a, 8'hff);
    io_read(8'h6a, rd);
    check(rd, 8'h00);
    io_read(8'h55, rd);
    check(rd, 8'h00);
    io_read(8'h68, rd);
    check(rd, 8'h00);
    $display("test registers done");
    // Every attribute mix, font table at 800H
    for (int k = 0; k < 32; k++) begin
      run_char(11'h400 + k[10:0], 4'($urandom % 16), {k[4:0], 11'h080 + 11'($urandom % 64)},
               16'($urandom % 65536), 1'b0);
    end
    $display("test attributes done");
    // Cursor placed by host moves the inversion
    io_write(8'h68, 8'h0a);
    io_write(8'h6a, 8'h00);
    io_write(8'h68, 8'h0e);
    io_write(8'h6a, 8'h05);
    io_write(8'h68, 8'h0f);
    io_write(8'h6a, 8'h21);
    run_char(11'h521, 4'h3, 16'h0090, 16'h0155, 1'b1);
    run_char(11'h522, 4'h3, 16'h0090, 16'h0155, 1'b0);
    io_write(8'h68, 8'h0a);
    io_write(8'h6a, 8'h20);
    $display("test cursor done");
    // Sync pins pass through to the CRT
    @(negedge clk_in);
    hs = 1'b1;
    vs = 1'b1;
    repeat (6) @(negedge clk_in);
    check({hs_o, vs_o}, 2'b11);
    hs = 1'b0;
    vs = 1'b0;
    // Falling levels must follow as well, not only the rise
    repeat (6) @(negedge clk_in);
    check({hs_o, vs_o}, 2'b00);
    $display("test sync done");
    // Second edge during a slow fetch is dropped and flagged
    slow = 1'b1;
    @(negedge clk_in);
    caddr = 11'h007;
    de = 1'b1;
    repeat (2) begin
      @(negedge clk_in);
      cclk = 1'b1;
      repeat (2) @(negedge clk_in);
      cclk = 1'b0;
    end
    repeat (60) @(negedge clk_in);
    de = 1'b0;
    slow = 1'b0;
    check(ovr, 1'b1);
    io_read(8'h68, rd);
    check(ovr, 1'b0);
    $display("test overrun done");
    report_and_stop();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    bad_count++;
    report_and_stop();
  end
endmodule : tb_char_cell_video_fetch

bind ccvf_video ccvf_video_monitor mon_u (.clk_in(clk_in), .nrst_in(nrst_in),
  .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_rdata_out(io_rdata_out),
  .crtc_hsync_in(crtc_hsync_in), .crtc_vsync_in(crtc_vsync_in), .crtc_row_in(crtc_row_in),
  .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in),
  .mem_data_in(mem_data_in), .video_on_out(video_on_out), .video_hi_out(video_hi_out),
  .hsync_out(hsync_out), .vsync_out(vsync_out));
